// File: src/scan_cfg_pkg.sv
// shared constants and types for the scan configuration access path
package scan_cfg_pkg;
   localparam int unsigned IR_WIDTH     = 6;
   localparam int unsigned PKT_WIDTH    = 16;
   localparam int unsigned STATUS_WIDTH = 32;
   localparam int unsigned CNT_WIDTH    = 4;
   localparam int unsigned SYNC_STAGES  = 2;

   localparam logic [IR_WIDTH-1:0] IR_CFG_IN  = 6'h05;
   localparam logic [IR_WIDTH-1:0] IR_READOUT = 6'h04;
   localparam logic [IR_WIDTH-1:0] IR_BYPASS  = 6'h3f;
   localparam logic [IR_WIDTH-1:0] IR_CAPTURE = 6'h01;
   localparam logic [CNT_WIDTH-1:0] PKT_LAST  = 4'hf;
   localparam logic [2:0] RESET_ONES          = 3'h5;

   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
      SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
   } tap_state_type;
endpackage

// File: src/tap_pins_if.sv
// synchronised scan pins and tck edge strobes between the sampler and the tap
`timescale 1ns/1ns
`default_nettype none
interface tap_pins_if;
   logic tck_rise;
   logic tck_fall;
   logic tms;
   logic tdi;
   modport src (output tck_rise, output tck_fall, output tms, output tdi);
   modport dst (input tck_rise, input tck_fall, input tms, input tdi);
endinterface
`default_nettype wire

// File: src/scan_pin_sampler.sv
// two-stage synchroniser and tck edge finder for the scan pins
`timescale 1ns/1ns
`default_nettype none
module scan_pin_sampler
   import scan_cfg_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic rstn,
   input  wire logic tck,
   input  wire logic tms,
   input  wire logic tdi,
   tap_pins_if.src   pins
);
   typedef struct packed {
      logic [2:0] meta;
      logic [2:0] sync;
      logic       tck_last;
   } sampler_state_type;

   sampler_state_type st_reg;
   sampler_state_type st_next;

   always_comb
   begin
      st_next          = st_reg;
      st_next.meta     = {tck, tms, tdi};
      // first stage feeds only the second
      st_next.sync     = st_reg.meta;
      st_next.tck_last = st_reg.sync[2];
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   // tms and tdi go through the same stages as tck, so they stay aligned to its edge
   assign pins.tck_rise = st_reg.sync[2] & ~st_reg.tck_last;
   assign pins.tck_fall = ~st_reg.sync[2] & st_reg.tck_last;
   assign pins.tms      = st_reg.sync[1];
   assign pins.tdi      = st_reg.sync[0];
endmodule
`default_nettype wire

// File: src/scan_cfg_access.sv
// tap controller with packet input and readout data registers
//
// Functional notes
// - words from packet register go to processor
// - both registers are tap data registers
// - reads in via packet register, out via readout
// - six-bit instruction lsb first, codes 05/04
// - data shifted msb first in shift-dr
// - config registers not readable via scan, only the status word
// - readout presents 32-bit status word
`timescale 1ns/1ns
`default_nettype none
module scan_cfg_access
   import scan_cfg_pkg::*;
(
   input  wire logic                    clk_sys,
   input  wire logic                    rstn,
   input  wire logic                    tck,
   input  wire logic                    tms,
   input  wire logic                    tdi,
   output logic                         tdo,
   output logic                         tdo_oe,
   output logic [PKT_WIDTH-1:0]         cfg_word,
   output logic                         cfg_word_valid,
   input  wire logic [STATUS_WIDTH-1:0] readout_word,
   output logic                         tap_in_reset
);
   // ----------------------------------------------------------------
   // pin sampling
   // ----------------------------------------------------------------
   tap_pins_if pins ();

   scan_pin_sampler u_sampler (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .tck     (tck),
      .tms     (tms),
      .tdi     (tdi),
      .pins    (pins)
   );

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      tap_state_type            tap;
      logic [IR_WIDTH-1:0]      ir_sr;
      logic [IR_WIDTH-1:0]      ir;
      logic [STATUS_WIDTH-1:0]  dr_sr;
      logic [CNT_WIDTH-1:0]     bit_cnt;
      logic [PKT_WIDTH-1:0]     word;
      logic                     word_valid;
      logic                     tdo;
      logic                     tdo_oe;
   } access_state_type;

   access_state_type st_reg;
   access_state_type st_next;

   logic rise;
   logic fall;
   logic tms_s;
   logic tdi_s;
   logic [PKT_WIDTH-1:0] pkt_shifted;

   assign rise        = pins.tck_rise;
   assign fall        = pins.tck_fall;
   assign tms_s       = pins.tms;
   assign tdi_s       = pins.tdi;
   assign pkt_shifted = {st_reg.dr_sr[PKT_WIDTH-2:0], tdi_s};

   // ----------------------------------------------------------------
   // tap and data registers
   // ----------------------------------------------------------------
   always_comb
   begin
      st_next            = st_reg;
      st_next.word_valid = 1'b0;
      if (rise)
      begin
         case (st_reg.tap)
            TLR:
            begin
               st_next.ir = IR_BYPASS;
            end
            CAP_IR:
            begin
               st_next.ir_sr = IR_CAPTURE;
            end
            SHIFT_IR:
            begin
               // lsb enters first, so new bits go in at the top
               st_next.ir_sr = {tdi_s, st_reg.ir_sr[IR_WIDTH-1:1]};
            end
            UPD_IR:
            begin
               st_next.ir = st_reg.ir_sr;
            end
            CAP_DR:
            begin
               st_next.bit_cnt = '0;
               if (st_reg.ir == IR_READOUT)
                  st_next.dr_sr = readout_word;
               else
                  st_next.dr_sr = '0;
            end
            SHIFT_DR:
            begin
               if (st_reg.ir == IR_CFG_IN)
               begin
                  // every completed word goes out, exit bit included
                  st_next.dr_sr   = {{(STATUS_WIDTH-PKT_WIDTH){1'b0}}, pkt_shifted};
                  st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
                  if (st_reg.bit_cnt == PKT_LAST)
                  begin
                     st_next.word       = pkt_shifted;
                     st_next.word_valid = 1'b1;
                  end
               end
               else if (st_reg.ir == IR_READOUT)
                  st_next.dr_sr = {st_reg.dr_sr[STATUS_WIDTH-2:0], tdi_s};
               else
                  st_next.dr_sr = {{(STATUS_WIDTH-1){1'b0}}, tdi_s};
            end
            default:
            begin
            end
         endcase
         case (st_reg.tap)
            TLR:      st_next.tap = tms_s ? TLR : RTI;
            RTI:      st_next.tap = tms_s ? SEL_DR : RTI;
            SEL_DR:   st_next.tap = tms_s ? SEL_IR : CAP_DR;
            CAP_DR:   st_next.tap = tms_s ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR: st_next.tap = tms_s ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR: st_next.tap = tms_s ? UPD_DR : PAUSE_DR;
            PAUSE_DR: st_next.tap = tms_s ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR: st_next.tap = tms_s ? UPD_DR : SHIFT_DR;
            UPD_DR:   st_next.tap = tms_s ? SEL_DR : RTI;
            SEL_IR:   st_next.tap = tms_s ? TLR : CAP_IR;
            CAP_IR:   st_next.tap = tms_s ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR: st_next.tap = tms_s ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR: st_next.tap = tms_s ? UPD_IR : PAUSE_IR;
            PAUSE_IR: st_next.tap = tms_s ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR: st_next.tap = tms_s ? UPD_IR : SHIFT_IR;
            UPD_IR:   st_next.tap = tms_s ? SEL_DR : RTI;
            default:  st_next.tap = TLR;
         endcase
      end
      // tdo moves on the falling edge so the host samples a settled bit
      if (fall)
      begin
         st_next.tdo_oe = (st_reg.tap == SHIFT_IR) || (st_reg.tap == SHIFT_DR);
         if (st_reg.tap == SHIFT_IR)
            st_next.tdo = st_reg.ir_sr[0];
         else if (st_reg.ir == IR_READOUT)
            st_next.tdo = st_reg.dr_sr[STATUS_WIDTH-1];
         else if (st_reg.ir == IR_CFG_IN)
            st_next.tdo = st_reg.dr_sr[PKT_WIDTH-1];
         else
            st_next.tdo = st_reg.dr_sr[0];
      end
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         st_reg     <= '0;
         st_reg.tap <= TLR;
         st_reg.ir  <= IR_BYPASS;
      end
      else
         st_reg <= st_next;
   end

   assign tdo            = st_reg.tdo;
   assign tdo_oe         = st_reg.tdo_oe;
   assign cfg_word       = st_reg.word;
   assign cfg_word_valid = st_reg.word_valid;
   assign tap_in_reset   = (st_reg.tap == TLR);

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   logic [2:0] ones_cnt;

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         ones_cnt <= '0;
      else if (rise)
         ones_cnt <= tms_s ? ((ones_cnt == RESET_ONES) ? ones_cnt : ones_cnt + 1'b1) : '0;
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   sequence rise_tms_low;
      rise && !tms_s;
   endsequence

   sequence cfg_last_bit;
      rise && st_reg.tap == SHIFT_DR && st_reg.ir == IR_CFG_IN && st_reg.bit_cnt == PKT_LAST;
   endsequence

   a_five_ones_reset: assert property (rise && tms_s && ones_cnt == (RESET_ONES - 3'h1)
      |=> st_reg.tap == TLR)
      else $error("five tms highs did not reset the tap");
   a_tlr_to_idle: assert property (st_reg.tap == TLR ##0 rise_tms_low
      |=> st_reg.tap == RTI)
      else $error("tms low in reset did not reach idle");
   a_word_pulse: assert property (cfg_word_valid |=> !cfg_word_valid)
      else $error("packet strobe longer than one cycle");
   a_word_from_cfgin: assert property (cfg_word_valid |-> st_reg.ir == IR_CFG_IN)
      else $error("packet word sent without packet instruction");
   a_word_content: assert property (cfg_last_bit
      |=> cfg_word_valid && cfg_word == $past(pkt_shifted))
      else $error("packet word wrong or missing");
   a_ir_update: assert property (rise && st_reg.tap == UPD_IR
      |=> st_reg.ir == $past(st_reg.ir_sr))
      else $error("instruction not updated");
   a_capture_status: assert property (rise && st_reg.tap == CAP_DR && st_reg.ir == IR_READOUT
      |=> st_reg.dr_sr == $past(readout_word))
      else $error("status word not captured");
   a_tdo_msb: assert property (fall && st_reg.tap == SHIFT_DR && st_reg.ir == IR_READOUT
      |=> tdo == $past(st_reg.dr_sr[STATUS_WIDTH-1]) && tdo_oe)
      else $error("readout bit order wrong");
   a_tlr_bypass: assert property (rise && st_reg.tap == TLR |=> st_reg.ir == IR_BYPASS)
      else $error("reset did not select bypass");
endmodule
`default_nettype wire

// File: sim/jtag_host_model.sv
// scan host model: drives tck, tms and tdi, samples tdo
`timescale 1ns/1ns
`default_nettype none
module jtag_host_model
   import scan_cfg_pkg::*;
(
   input  wire logic clk_sys,
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo
);
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // ---------------------------------------------------------------
   // one tck period of 8 clk_sys; tck stands low between calls
   // ---------------------------------------------------------------
   task automatic step(input logic m, input logic d, output logic o);
      @(posedge clk_sys);
      tms <= m;
      tdi <= d;
      repeat (3) @(posedge clk_sys);
      tck <= 1'b1;
      repeat (3) @(posedge clk_sys);
      o = tdo;
      @(posedge clk_sys);
      tck <= 1'b0;
      tdi <= ~d; // released line, never the last value
   endtask
   task automatic tap_reset();
      logic o;
      repeat (5) step(1'b1, 1'b0, o);
   endtask
   task automatic load_ir(input int highs, input logic [IR_WIDTH-1:0] code);
      logic o;
      repeat (highs) step(1'b1, 1'b0, o);
      repeat (2) step(1'b0, 1'b0, o);
      for (int i = 0; i < IR_WIDTH; i++)
         step(i == IR_WIDTH - 1, code[i], o);
      repeat (2) step(1'b1, 1'b0, o);
      repeat (2) step(1'b0, 1'b0, o);
   endtask
   task automatic shift_dr(input int n, input logic [127:0] din, output logic [127:0] dout);
      dout = '0;
      for (int i = n - 1; i >= 0; i--)
         step(i == 0, din[i], dout[i]);
   endtask
endmodule
`default_nettype wire

// File: sim/jtag_config_register_access_tb.sv
// self-checking bench for the scan configuration access path
`timescale 1ns/1ns
`default_nettype none
module jtag_config_register_access_tb;
   import scan_cfg_pkg::*;
   logic                    clk_sys = 1'b0;
   logic                    rstn;
   logic                    tck;
   logic                    tms;
   logic                    tdi;
   logic                    tdo;
   logic                    tdo_oe;
   logic [PKT_WIDTH-1:0]    cfg_word;
   logic                    cfg_word_valid;
   logic                    tap_in_reset;
   logic [STATUS_WIDTH-1:0] status_val = 32'hc3a5_0f96;
   logic [PKT_WIDTH-1:0]    words[$];
   logic [127:0]            d;
   int                      n_errors = 0;
   int                      samples_checked = 0;
   always #2 clk_sys = ~clk_sys;
   jtag_host_model host_u (.clk_sys(clk_sys), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
   scan_cfg_access dut_u (.clk_sys(clk_sys), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi),
      .tdo(tdo), .tdo_oe(tdo_oe), .cfg_word(cfg_word), .cfg_word_valid(cfg_word_valid),
      .readout_word(status_val), .tap_in_reset(tap_in_reset));
   always @(posedge clk_sys)
      if (cfg_word_valid === 1'b1)
         words.push_back(cfg_word);
   // ---------------------------------------------------------------
   // shared helpers
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      samples_checked++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // bounded wait, valid lags the tck edge by a few clk_sys
   task automatic wait_words(input int n);
      for (int k = 0; k < 40 && words.size() < n; k++)
         @(posedge clk_sys);
      if (words.size() < n)
      begin
         n_errors++;
         $display("[FAIL] %0t packet words missing", $time);
         summarize();
      end
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic test_reset_state();
      logic o;
      check(tap_in_reset, 1, "reset tlr");
      check(tdo_oe, 0, "reset oe");
      host_u.tap_reset();
      check(tap_in_reset, 1, "five ones");
      host_u.step(1'b0, 1'b0, o);
      repeat (4) @(posedge clk_sys);
      check(tap_in_reset, 0, "to idle");
      check(tdo_oe, 0, "idle oe");
      $display("test_reset_state done");
   endtask
   task automatic test_status_read();
      logic [PKT_WIDTH-1:0] exp[7] = '{16'haa99, 16'h5566, 16'h2901, 16'h2000, 16'h2000,
                                       16'h2000, 16'h2000};
      words.delete();
      host_u.load_ir(2, IR_CFG_IN);
      host_u.shift_dr(112, {exp[0], exp[1], exp[2], exp[3], exp[4], exp[5], exp[6]}, d);
      wait_words(7);
      check(words.size(), 7, "word count");
      foreach (exp[i])
         check(words[i], exp[i], "packet word");
      host_u.load_ir(3, IR_READOUT);
      // tdo enable follows the first tck fall inside shift-dr
      repeat (4) @(posedge clk_sys);
      check(tdo_oe, 1, "shift oe");
      host_u.shift_dr(32, '0, d);
      check(d[31:0], status_val, "status out");
      check(words.size(), 7, "readout not forwarded");
      host_u.tap_reset();
      repeat (4) @(posedge clk_sys);
      check(tap_in_reset, 1, "end reset");
      check(tdo_oe, 0, "end oe");
      $display("test_status_read done");
   endtask
   task automatic test_bypass_partial();
      logic o;
      words.delete();
      host_u.step(1'b0, 1'b0, o);
      host_u.load_ir(2, 6'h2a);
      host_u.shift_dr(8, 8'hb4, d);
      check(d[7:0], 8'h5a, "bypass delay");
      check(words.size(), 0, "bypass silent");
      host_u.load_ir(3, IR_CFG_IN);
      host_u.shift_dr(20, 20'h1234_5, d);
      wait_words(1);
      repeat (12) @(posedge clk_sys);
      check(words.size(), 1, "partial dropped");
      check(words[0], 16'h1234, "first word");
      host_u.tap_reset();
      $display("test_bypass_partial done");
   endtask
   initial
   begin
      rstn = 1'b0;
      repeat (20) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      test_reset_state();
      test_status_read();
      test_bypass_partial();
      summarize();
   end
endmodule
`default_nettype wire
